// ==== can_node_setup.sv ====
// Node identifier, setting-service wait and bit-rate setup for a CAN node
`default_nettype none
module can_node_setup (
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        rx_valid_in,
	input  wire logic [10:0] rx_can_id_in,
	input  wire logic [63:0] rx_data_in,
	input  wire logic        probe_ok_in,
	input  wire logic        probe_err_in,
	input  wire logic        obj_rd_in,
	input  wire logic [15:0] obj_index_in,
	input  wire logic [7:0]  obj_sub_in,
	output logic             obj_valid_out,
	output logic             obj_err_out,
	output logic [7:0]       obj_data_out,
	output logic             tx_valid_out,
	output logic [10:0]      tx_can_id_out,
	output logic [63:0]      tx_data_out,
	output logic [2:0]       rate_try_out,
	output logic             rate_known_out,
	output logic [7:0]       node_id_out,
	output logic             configured_out,
	output logic             in_svc_wait_out,
	output logic             cfg_mode_out,
	output logic             nmt_init_go_out,
	output logic             frame_accept_out
);
	can_cfg_pkg::node_state_t state_r;
	logic [7:0] rate_sel_r;
	logic [1:0] probe_cnt_r;
	logic       vendor_hit_r;
	logic       product_hit_r;
	logic       svc_frame;
	logic       rx_take;
	logic [7:0] cs;
	logic [7:0] arg1;
	logic [7:0] arg2;
	logic [31:0] arg32;
	nv_store_if nv ();

	nv_store u_store (
		.core_clk_in (core_clk_in),
		.port        (nv.mem)
	);

	function automatic logic id_valid(input logic [7:0] id);
		return (id >= can_cfg_pkg::NODE_ID_MIN) && (id <= can_cfg_pkg::NODE_ID_MAX);
	endfunction

	function automatic logic rate_valid(input logic [7:0] idx);
		return (idx <= can_cfg_pkg::RATE_IDX_MAX) || (idx == can_cfg_pkg::RATE_AUTO);
	endfunction

	function automatic logic [63:0] answer(input logic [7:0] c, input logic [7:0] e);
		return {48'h0000_0000_0000, e, c};
	endfunction

	// Frame decode; nothing is looked at before the rate is known
	assign rx_take   = rx_valid_in && (state_r == can_cfg_pkg::ST_WAIT_ID
		|| state_r == can_cfg_pkg::ST_RUN);
	assign svc_frame = rx_take && (rx_can_id_in == can_cfg_pkg::SVC_ID_FROM_MASTER);
	assign cs        = rx_data_in[7:0];
	assign arg1      = rx_data_in[15:8];
	assign arg2      = rx_data_in[23:16];
	assign arg32     = rx_data_in[39:8];

	// Store port: read at start-up, write on store command
	assign nv.rd_en   = (state_r == can_cfg_pkg::ST_LOAD_REQ);
	assign nv.rd_addr = can_cfg_pkg::NV_ADDR_CFG;
	assign nv.wr_en   = svc_frame && cfg_mode_out && (cs == can_cfg_pkg::CS_STORE);
	assign nv.wr_addr = can_cfg_pkg::NV_ADDR_CFG;
	assign nv.wr_data = {rate_sel_r, node_id_out};

	// Start-up sequence, rate search and wait for an identifier
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r         <= can_cfg_pkg::ST_LOAD_REQ;
			rate_try_out    <= 3'h0;
			probe_cnt_r     <= 2'h0;
			rate_known_out  <= 1'b0;
			nmt_init_go_out <= 1'b0;
		end else begin
			nmt_init_go_out <= 1'b0;
			unique case (state_r)
				can_cfg_pkg::ST_LOAD_REQ: begin
					state_r <= can_cfg_pkg::ST_LOAD_WAIT;
				end
				can_cfg_pkg::ST_LOAD_WAIT: begin
					// Blank or damaged stored rate falls back to the search
					if (nv.rd_data[15:8] == can_cfg_pkg::RATE_AUTO
						|| !rate_valid(nv.rd_data[15:8])) begin
						state_r       <= can_cfg_pkg::ST_DETECT;
					end else begin
						rate_known_out <= 1'b1;
						state_r        <= can_cfg_pkg::ST_WAIT_ID;
					end
				end
				can_cfg_pkg::ST_DETECT: begin
					// First clean frame locks the candidate under trial
					if (probe_ok_in) begin
						rate_known_out <= 1'b1;
						state_r        <= can_cfg_pkg::ST_WAIT_ID;
					end else if (probe_err_in) begin
						if (probe_cnt_r == can_cfg_pkg::PROBES_PER_RATE - 2'h1) begin
							probe_cnt_r  <= 2'h0;
							rate_try_out <= (rate_try_out == can_cfg_pkg::RATE_CANDIDATES_M1)
								? 3'h0 : rate_try_out + 3'h1;
						end else begin
							probe_cnt_r <= probe_cnt_r + 2'h1;
						end
					end
				end
				can_cfg_pkg::ST_WAIT_ID: begin
					// Leave the wait only with a valid identifier and config mode closed
					if (id_valid(node_id_out) && !cfg_mode_out) begin
						state_r         <= can_cfg_pkg::ST_RUN;
						nmt_init_go_out <= 1'b1;
					end
				end
				can_cfg_pkg::ST_RUN: begin
					state_r <= can_cfg_pkg::ST_RUN;
				end
				default: begin
					state_r <= can_cfg_pkg::ST_LOAD_REQ;
				end
			endcase
		end
	end

	// Identifier and rate selection, loaded from store then set by service frames
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			node_id_out <= can_cfg_pkg::NODE_ID_UNCONF;
			rate_sel_r  <= can_cfg_pkg::RATE_AUTO;
		end else if (state_r == can_cfg_pkg::ST_LOAD_WAIT) begin
			node_id_out <= id_valid(nv.rd_data[7:0]) ? nv.rd_data[7:0]
				: can_cfg_pkg::NODE_ID_UNCONF;
			rate_sel_r  <= rate_valid(nv.rd_data[15:8]) ? nv.rd_data[15:8]
				: can_cfg_pkg::RATE_AUTO;
		end else if (svc_frame && cfg_mode_out) begin
			if (cs == can_cfg_pkg::CS_CFG_NODE_ID
				&& (id_valid(arg1) || arg1 == can_cfg_pkg::NODE_ID_UNCONF)) begin
				node_id_out <= arg1;
			end
			if (cs == can_cfg_pkg::CS_CFG_BIT_TIMING && arg1 == can_cfg_pkg::TIMING_TABLE_STD
				&& rate_valid(arg2)) begin
				rate_sel_r <= arg2;
			end
		end
	end

	// Configuration mode and selective address matching
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg_mode_out  <= 1'b0;
			vendor_hit_r  <= 1'b0;
			product_hit_r <= 1'b0;
		end else if (svc_frame) begin
			unique case (cs)
				can_cfg_pkg::CS_SWITCH_GLOBAL: begin
					cfg_mode_out <= (arg1 == can_cfg_pkg::MODE_CONFIG);
				end
				can_cfg_pkg::CS_SEL_VENDOR: begin
					vendor_hit_r <= (arg32 == can_cfg_pkg::VENDOR_CODE);
				end
				can_cfg_pkg::CS_SEL_PRODUCT: begin
					product_hit_r <= (arg32 == can_cfg_pkg::PRODUCT_CODE);
				end
				can_cfg_pkg::CS_SEL_REVISION: begin
					vendor_hit_r <= vendor_hit_r;
				end
				can_cfg_pkg::CS_SEL_SERIAL: begin
					// Serial is not checked; one node per segment is assumed
					if (vendor_hit_r && product_hit_r) begin
						cfg_mode_out <= 1'b1;
					end
					vendor_hit_r  <= 1'b0;
					product_hit_r <= 1'b0;
				end
				default: begin
					cfg_mode_out <= cfg_mode_out;
				end
			endcase
		end
	end

	// Answers to the master
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_valid_out  <= 1'b0;
			tx_can_id_out <= can_cfg_pkg::SVC_ID_FROM_NODE;
			tx_data_out   <= 64'h0000_0000_0000_0000;
		end else begin
			tx_valid_out  <= 1'b0;
			tx_can_id_out <= can_cfg_pkg::SVC_ID_FROM_NODE;
			if (svc_frame && cfg_mode_out && cs == can_cfg_pkg::CS_CFG_NODE_ID) begin
				tx_valid_out <= 1'b1;
				tx_data_out  <= answer(cs, (id_valid(arg1) || arg1 == can_cfg_pkg::NODE_ID_UNCONF)
					? can_cfg_pkg::ERR_NONE : can_cfg_pkg::ERR_RANGE);
			end else if (svc_frame && cfg_mode_out && cs == can_cfg_pkg::CS_CFG_BIT_TIMING) begin
				tx_valid_out <= 1'b1;
				tx_data_out  <= answer(cs, (rate_valid(arg2) && arg1 == can_cfg_pkg::TIMING_TABLE_STD)
					? can_cfg_pkg::ERR_NONE : can_cfg_pkg::ERR_RANGE);
			end else if (svc_frame && cfg_mode_out && cs == can_cfg_pkg::CS_STORE) begin
				tx_valid_out <= 1'b1;
				tx_data_out  <= answer(cs, can_cfg_pkg::ERR_NONE);
			end else if (svc_frame && cs == can_cfg_pkg::CS_SEL_SERIAL
				&& vendor_hit_r && product_hit_r) begin
				tx_valid_out <= 1'b1;
				tx_data_out  <= answer(can_cfg_pkg::CS_SEL_ANSWER, can_cfg_pkg::ERR_NONE);
			end
		end
	end

	// Object read of the rate selection; read-only, no write path exists
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			obj_valid_out <= 1'b0;
			obj_err_out   <= 1'b0;
			obj_data_out  <= 8'h00;
		end else begin
			obj_valid_out <= obj_rd_in;
			obj_err_out   <= 1'b0;
			obj_data_out  <= 8'h00;
			if (obj_rd_in) begin
				if (obj_index_in == can_cfg_pkg::RATE_READBACK_IDX
					&& obj_sub_in == can_cfg_pkg::RATE_READBACK_SUB) begin
					obj_data_out <= rate_sel_r;
				end else begin
					obj_err_out <= 1'b1;
				end
			end
		end
	end

	// Status flags
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			configured_out   <= 1'b0;
			in_svc_wait_out  <= 1'b0;
			frame_accept_out <= 1'b0;
		end else begin
			configured_out   <= id_valid(node_id_out);
			in_svc_wait_out  <= (state_r == can_cfg_pkg::ST_WAIT_ID);
			frame_accept_out <= (state_r == can_cfg_pkg::ST_RUN);
		end
	end
endmodule
`default_nettype wire

// ==== can_cfg_pkg.sv ====
// Constants, types and register map for CAN node identifier and bit-rate setup
`default_nettype none
package can_cfg_pkg;
	localparam logic [7:0]  NODE_ID_MIN       = 8'h01;
	localparam logic [7:0]  NODE_ID_MAX       = 8'h7F;
	localparam logic [7:0]  NODE_ID_UNCONF    = 8'hFF;
	localparam logic [7:0]  RATE_IDX_MAX      = 8'h04;
	localparam logic [7:0]  RATE_AUTO         = 8'hFF;
	localparam logic [1:0]  PROBES_PER_RATE   = 2'h3;
	localparam logic [2:0]  RATE_CANDIDATES_M1 = 3'h7;
	localparam logic [10:0] SVC_ID_FROM_MASTER = 11'h7E5;
	localparam logic [10:0] SVC_ID_FROM_NODE   = 11'h7E4;
	localparam logic [15:0] RATE_READBACK_IDX  = 16'h2400;
	localparam logic [7:0]  RATE_READBACK_SUB  = 8'h00;
	// Service command specifiers
	localparam logic [7:0]  CS_SWITCH_GLOBAL  = 8'h04;
	localparam logic [7:0]  CS_CFG_NODE_ID    = 8'h11;
	localparam logic [7:0]  CS_CFG_BIT_TIMING = 8'h13;
	localparam logic [7:0]  CS_STORE          = 8'h17;
	localparam logic [7:0]  CS_SEL_VENDOR     = 8'h40;
	localparam logic [7:0]  CS_SEL_PRODUCT    = 8'h41;
	localparam logic [7:0]  CS_SEL_REVISION   = 8'h42;
	localparam logic [7:0]  CS_SEL_SERIAL     = 8'h43;
	localparam logic [7:0]  CS_SEL_ANSWER     = 8'h44;
	localparam logic [7:0]  MODE_CONFIG       = 8'h01;
	localparam logic [7:0]  ERR_NONE          = 8'h00;
	localparam logic [7:0]  ERR_RANGE         = 8'h01;
	localparam logic [7:0]  TIMING_TABLE_STD  = 8'h00;
	// Identity values below are arbitrary
	localparam logic [31:0] VENDOR_CODE       = 32'h0000_0A5A;
	localparam logic [31:0] PRODUCT_CODE      = 32'h0000_1234;
	// Non-volatile word layout
	localparam int          NV_DEPTH          = 2;
	localparam int          NV_AW             = 1;
	localparam logic [0:0]  NV_ADDR_CFG       = 1'h0;
	localparam logic [15:0] NV_BLANK          = 16'hFFFF;

	typedef enum logic [2:0] {
		ST_LOAD_REQ  = 3'b000,
		ST_LOAD_WAIT = 3'b001,
		ST_DETECT    = 3'b010,
		ST_WAIT_ID   = 3'b011,
		ST_RUN       = 3'b100
	} node_state_t;
endpackage
`default_nettype wire

// ==== nv_store_if.sv ====
// Carrier between setup logic and its non-volatile word store
`default_nettype none
interface nv_store_if;
	logic                          wr_en;
	logic [can_cfg_pkg::NV_AW-1:0] wr_addr;
	logic [15:0]                   wr_data;
	logic                          rd_en;
	logic [can_cfg_pkg::NV_AW-1:0] rd_addr;
	logic [15:0]                   rd_data;
	modport user (output wr_en, output wr_addr, output wr_data,
		output rd_en, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data,
		input rd_en, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ==== nv_store.sv ====
// Small word store standing in for non-volatile configuration memory
`default_nettype none
module nv_store (
	input  wire logic  core_clk_in,
	nv_store_if.mem    port
);
	logic [15:0] mem_r [can_cfg_pkg::NV_DEPTH];

	// Contents are not reset so they survive a reset; blank words read as unconfigured
	initial begin
		for (int i = 0; i < can_cfg_pkg::NV_DEPTH; i++) begin
			mem_r[i] = can_cfg_pkg::NV_BLANK;
		end
	end

	// Write port
	always_ff @(posedge core_clk_in) begin
		if (port.wr_en) begin
			mem_r[port.wr_addr] <= port.wr_data;
		end
	end

	// Registered read data
	always_ff @(posedge core_clk_in) begin
		if (port.rd_en) begin
			port.rd_data <= mem_r[port.rd_addr];
		end
	end
endmodule
`default_nettype wire

// ==== can_node_setup_props.sv ====
// Concurrent checks on the ports of the CAN node setup block
`default_nettype none
module can_node_setup_props (
	input wire logic        core_clk_in,
	input wire logic        rst_n_in,
	input wire logic        rx_valid_in,
	input wire logic [10:0] rx_can_id_in,
	input wire logic        obj_rd_in,
	input wire logic [15:0] obj_index_in,
	input wire logic [7:0]  obj_sub_in,
	input wire logic        obj_valid_out,
	input wire logic        obj_err_out,
	input wire logic [7:0]  obj_data_out,
	input wire logic        tx_valid_out,
	input wire logic [10:0] tx_can_id_out,
	input wire logic [63:0] tx_data_out,
	input wire logic        rate_known_out,
	input wire logic [7:0]  node_id_out,
	input wire logic        configured_out,
	input wire logic        nmt_init_go_out,
	input wire logic        frame_accept_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so shared clocking and reset
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	// Readback answers
	a_obj_answer: assert property (obj_rd_in |=> obj_valid_out)
		else $error("object read not answered");
	a_obj_cause: assert property (obj_valid_out |-> $past(obj_rd_in))
		else $error("object answer without read");
	a_obj_err: assert property (obj_rd_in |=> obj_err_out ==
		($past(obj_index_in) != 16'h2400 || $past(obj_sub_in) != 8'h00))
		else $error("object error flag wrong");
	a_rate_code: assert property (obj_valid_out && !obj_err_out |->
		(obj_data_out <= 8'h04 || obj_data_out == 8'hFF))
		else $error("rate readback out of range");
	// Identifier state, flag lags by one cycle
	a_id_range: assert property (configured_out |->
		$past(node_id_out) inside {[8'h01:8'h7F]})
		else $error("configured with bad identifier");
	a_unconf_flag: assert property ($past(node_id_out) == 8'hFF |-> !configured_out)
		else $error("unconfigured node flagged configured");
	// Service frames
	a_tx_ident: assert property (tx_valid_out |-> tx_can_id_out == 11'h7E4)
		else $error("answer frame identifier wrong");
	a_tx_cause: assert property (tx_valid_out |->
		$past(rx_valid_in) && $past(rx_can_id_in) == 11'h7E5)
		else $error("answer without master frame");
	a_quiet_detect: assert property (!rate_known_out && rx_valid_in |=> !tx_valid_out)
		else $error("frame answered before rate known");
	a_accept_known: assert property (frame_accept_out |-> rate_known_out)
		else $error("frames accepted before rate known");
	a_nmt_pulse: assert property (nmt_init_go_out |=> !nmt_init_go_out)
		else $error("network init start not a pulse");
	a_range_keep: assert property (tx_valid_out && tx_data_out[15:8] == 8'h01 |->
		$stable(node_id_out))
		else $error("identifier changed on range error");

	c_nmt: cover property (nmt_init_go_out);
	c_range_err: cover property (tx_valid_out && tx_data_out[15:8] == 8'h01);
	c_rate_lock: cover property ($rose(rate_known_out));
endmodule

bind can_node_setup can_node_setup_props chk (.core_clk_in, .rst_n_in, .rx_valid_in, .rx_can_id_in,
	.obj_rd_in, .obj_index_in, .obj_sub_in, .obj_valid_out, .obj_err_out, .obj_data_out,
	.tx_valid_out, .tx_can_id_out, .tx_data_out, .rate_known_out, .node_id_out,
	.configured_out, .nmt_init_go_out, .frame_accept_out);
`default_nettype wire

// ==== lss_master_model.sv ====
// Bus master model: service frames and rate probe results
`default_nettype none
module lss_master_model (
	input  wire logic        core_clk_in,
	input  wire logic        send_in,
	input  wire logic [10:0] id_in,
	input  wire logic [63:0] data_in,
	input  wire logic [1:0]  probe_in,
	output logic             rx_valid_out,
	output logic [10:0]      rx_can_id_out,
	output logic [63:0]      rx_data_out,
	output logic             probe_ok_out,
	output logic             probe_err_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_valid_out = 1'b0;
		rx_can_id_out = 11'h000;
		rx_data_out = 64'h0;
		probe_ok_out = 1'b0;
		probe_err_out = 1'b0;
	end
	// Frame lines scramble between frames so stale bytes never look valid
	always @(posedge core_clk_in) begin
		rx_valid_out <= send_in;
		rx_can_id_out <= send_in ? id_in : ~rx_can_id_out;
		rx_data_out <= send_in ? data_in : ~rx_data_out;
		probe_ok_out <= probe_in[0];
		probe_err_out <= probe_in[1];
	end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the CAN node setup block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in, rst_n_in, obj_rd_in, send, rx_valid_in, probe_ok_in, probe_err_in;
	logic obj_valid_out, obj_err_out, tx_valid_out, rate_known_out, configured_out;
	logic in_svc_wait_out, cfg_mode_out, nmt_init_go_out, frame_accept_out;
	logic [1:0]  probe;
	logic [2:0]  rate_try_out;
	logic [7:0]  obj_sub_in, obj_data_out, node_id_out;
	logic [10:0] rx_can_id_in, frm_id, tx_can_id_out;
	logic [15:0] obj_index_in;
	logic [63:0] rx_data_in, frm_data, tx_data_out;
	int          error_cnt, compares, cyc, i, k;

	can_node_setup dut (.core_clk_in, .rst_n_in, .rx_valid_in, .rx_can_id_in, .rx_data_in,
		.probe_ok_in, .probe_err_in, .obj_rd_in, .obj_index_in, .obj_sub_in, .obj_valid_out,
		.obj_err_out, .obj_data_out, .tx_valid_out, .tx_can_id_out, .tx_data_out,
		.rate_try_out, .rate_known_out, .node_id_out, .configured_out, .in_svc_wait_out,
		.cfg_mode_out, .nmt_init_go_out, .frame_accept_out);
	lss_master_model master (.core_clk_in, .send_in(send), .id_in(frm_id), .data_in(frm_data),
		.probe_in(probe), .rx_valid_out(rx_valid_in), .rx_can_id_out(rx_can_id_in),
		.rx_data_out(rx_data_in), .probe_ok_out(probe_ok_in), .probe_err_out(probe_err_in));

	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	// Answer expectation packs {answered, error, command}
	task svc(input logic [7:0] cs, input logic [31:0] arg, input logic [16:0] exp);
		@(posedge core_clk_in);
		send <= 1'b1;
		frm_id <= 11'h7E5;
		frm_data <= {24'h0, arg, cs};
		@(posedge core_clk_in);
		send <= 1'b0;
		@(posedge core_clk_in);
		#1;
		chk("answer", exp[16], tx_valid_out);
		if (exp[16]) begin
			chk("tx data", {48'h0, exp[15:0]}, tx_data_out);
			chk("tx id", 11'h7E4, tx_can_id_out);
		end
	endtask
	task rd(input logic [15:0] idx, input logic [8:0] exp);
		@(posedge core_clk_in);
		obj_rd_in <= 1'b1;
		obj_index_in <= idx;
		@(posedge core_clk_in);
		obj_rd_in <= 1'b0;
		#1;
		chk("obj valid", 1'b1, obj_valid_out);
		chk("obj err", exp[8], obj_err_out);
		chk("obj data", exp[7:0], obj_data_out);
	endtask
	task prb(input logic [1:0] kind, input int n);
		repeat (n) begin
			@(posedge core_clk_in);
			probe <= kind;
			@(posedge core_clk_in);
			probe <= 2'h0;
		end
		repeat (2) @(posedge core_clk_in);
		#1;
	endtask
	task finish_test;
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	// Hang guard, far above the about 190 cycles the sequence needs
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			finish_test;
		end
	end

	initial begin
		{rst_n_in, obj_rd_in, send, probe, frm_id, frm_data, obj_index_in, obj_sub_in} = '0;
		{error_cnt, compares, cyc} = '0;
		repeat (8) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		#1;
		chk("node id", 8'hFF, node_id_out);
		chk("configured", 1'b0, configured_out);
		rd(16'h2400, 9'h0FF);
		rd(16'h2401, 9'h100);
		svc(8'h04, 32'h1, 17'h0);
		chk("cfg mode", 1'b0, cfg_mode_out);
		// Three failed probes per candidate, wrapping after eight
		for (k = 0; k < 8; k++) begin
			prb(2'h2, 3);
			chk("rate try", (k + 1) % 8, rate_try_out);
		end
		prb(2'h1, 1);
		chk("rate known", 1'b1, rate_known_out);
		chk("svc wait", 1'b1, in_svc_wait_out);
		svc(8'h11, 32'h20, 17'h0);
		svc(8'h04, 32'h1, 17'h0);
		svc(8'h11, 32'h0, 17'h10111);
		svc(8'h11, 32'h80, 17'h10111);
		chk("node id", 8'hFF, node_id_out);
		svc(8'h11, 32'h7F, 17'h10011);
		chk("node id", 8'h7F, node_id_out);
		svc(8'h13, 32'h0500, 17'h10113);
		rd(16'h2400, 9'h0FF);
		for (k = 0; k < 5; k++) begin
			svc(8'h13, {16'h0, k[7:0], 8'h00}, 17'h10013);
			rd(16'h2400, {1'b0, k[7:0]});
		end
		svc(8'h13, 32'hFF00, 17'h10013);
		rd(16'h2400, 9'h0FF);
		svc(8'h13, 32'h0300, 17'h10013);
		// Wrong timing table must leave the fixed rate in place
		svc(8'h13, 32'h0101, 17'h10113);
		rd(16'h2400, 9'h003);
		svc(8'h17, 32'h0, 17'h10017);
		svc(8'h04, 32'h0, 17'h0);
		i = 0;
		repeat (6) begin
			@(posedge core_clk_in);
			#1;
			if (nmt_init_go_out === 1'b1) i++;
		end
		chk("nmt go", 1, i);
		chk("accept", 1'b1, frame_accept_out);
		chk("svc wait", 1'b0, in_svc_wait_out);
		// Selective open with zero revision
		svc(8'h40, can_cfg_pkg::VENDOR_CODE, 17'h0);
		svc(8'h41, can_cfg_pkg::PRODUCT_CODE, 17'h0);
		svc(8'h42, 32'h0, 17'h0);
		svc(8'h43, 32'h5, 17'h10044);
		chk("cfg mode", 1'b1, cfg_mode_out);
		svc(8'h04, 32'h0, 17'h0);
		// Second power-up must bring back the stored setup
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		repeat (8) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		#1;
		chk("node id", 8'h7F, node_id_out);
		chk("configured", 1'b1, configured_out);
		chk("rate known", 1'b1, rate_known_out);
		rd(16'h2400, 9'h003);
		finish_test;
	end
endmodule
`default_nettype wire
